// ---- src/lrcd_pkg.sv ----
// Shared constants and types for the lane route configuration decoder
package lrcd_pkg;
  localparam int GAIN_W = 4;
  localparam int NUM_CH = 4;

  // Channel index: one crosspoint per lane pair
  localparam int CH_RX1 = 0;
  localparam int CH_RX2 = 1;
  localparam int CH_TX1 = 2;
  localparam int CH_TX2 = 3;

  // Register offsets
  localparam logic [7:0] OFS_CONFIG = 8'h0A;
  localparam logic [7:0] OFS_CH_REVERSE = 8'h0B;
  localparam logic [7:0] OFS_UFP_RX_GAIN = 8'h10;
  localparam logic [7:0] OFS_UFP_TX_GAIN = 8'h11;
  localparam logic [7:0] OFS_AUX_MONITOR = 8'h13;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_DFP_RX_GAIN = 8'h20;
  localparam logic [7:0] OFS_DFP_TX_GAIN = 8'h21;

  // Field positions of the configuration register and the aux monitor disable bit
  localparam int CFG_USB_BIT = 0;
  localparam int CFG_ALT_BIT = 1;
  localparam int CFG_ORIENT_BIT = 2;
  localparam int CFG_SIDE_BIT = 3;
  localparam int CFG_FAMILY_BIT = 4;
  localparam int CFG_SB_OVR_LSB = 5;
  localparam int MON_DISABLE_BIT = 7;

  // Reset values
  localparam logic [7:0] RST_CONFIG = 8'h00;
  localparam logic [3:0] RST_CH_REVERSE = 4'h0;
  localparam logic [7:0] RST_GAIN = 8'h00;
  localparam logic [7:0] RST_AUX_MONITOR = 8'h80;

  // Channel reverse codes that fall back to the pin behaviour
  localparam logic [3:0] REV_NONE = 4'h0;
  localparam logic [3:0] REV_ALL = 4'hF;

  // Sideband override codes
  localparam logic [1:0] SB_AUTO = 2'h0;
  localparam logic [1:0] SB_STRAIGHT = 2'h1;
  localparam logic [1:0] SB_CROSSED = 2'h2;
  localparam logic [1:0] SB_OPEN = 2'h3;

  // Debounce time and its cycle count at the core clock
  localparam int CLK_FREQ_KHZ = 250000;
  localparam int DEBOUNCE_MS = 16;
  localparam int DEBOUNCE_CYCLES = DEBOUNCE_MS * CLK_FREQ_KHZ;

  typedef enum logic [1:0] {
    RM_OFF,
    RM_USB,
    RM_ALT4,
    RM_USB_ALT2
  } lrcd_route_t;

  typedef struct packed {
    logic alt_family_sel;
    logic side_sel;
    logic alt_enable_sel;
    logic usb_enable_sel;
    logic orientation_sel;
  } lrcd_sel_t;

  typedef struct packed {
    logic p_to_sb1;
    logic n_to_sb2;
    logic p_to_sb2;
    logic n_to_sb1;
  } lrcd_sbu_t;
endpackage : lrcd_pkg

// ---- src/lrcd_debounce.sv ----
// Level debouncer for the enable and orientation pins
`timescale 1ns/100ps
`default_nettype none
module lrcd_debounce #(
  parameter int WIDTH = 3,
  parameter int CYCLES = lrcd_pkg::DEBOUNCE_CYCLES
) (
  input wire logic clk, // Core clock
  input wire logic reset_n, // Synchronous reset
  input wire logic [WIDTH-1:0] raw, // Pin levels
  output logic [WIDTH-1:0] stable // Debounced levels
);
  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST_COUNT = CW'(CYCLES - 1);

  generate
    if (CYCLES < 1 || WIDTH < 1) begin : g_bad
      $error("lrcd_debounce: CYCLES and WIDTH must be at least 1");
    end
  endgenerate

  typedef struct packed {
    logic [WIDTH-1:0] stable;
    logic [WIDTH-1:0] last;
    logic [CW-1:0] count;
  } lrcd_db_state_t;

  lrcd_db_state_t s, next_s;

  always_comb begin
    next_s = s;
    if (raw != s.last) begin
      next_s.last = raw;
      next_s.count = '0;
    end else if (s.stable != s.last) begin
      if (s.count == LAST_COUNT) begin
        next_s.stable = s.last;
      end else begin
        next_s.count = s.count + CW'(1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign stable = s.stable;

  a_db_settle_apply: assert property (
    @(posedge clk) disable iff (!reset_n)
    $past(reset_n) && $past(s.count == LAST_COUNT && raw == s.last
      && s.stable != s.last) |-> s.stable == $past(s.last))
    else $error("debounced level not applied after settle time");

  a_db_count_bound: assert property (
    @(posedge clk) disable iff (!reset_n)
    s.count <= LAST_COUNT)
    else $error("debounce counter ran past its limit");
endmodule : lrcd_debounce
`default_nettype wire

// ---- src/lrcd_route.sv ----
// Crosspoint decode from the five selects to per-channel enable and direction
`timescale 1ns/100ps
`default_nettype none
module lrcd_route (
  input wire lrcd_pkg::lrcd_sel_t sel, // Effective selects
  input wire logic custom_ok, // Custom alternate mode allowed
  output lrcd_pkg::lrcd_route_t route, // Decoded route mode
  output logic [3:0] ch_en, // Channel enabled
  output logic [3:0] ch_u2d, // Upstream to downstream before reversal
  output logic dp_on, // Four or two DisplayPort lanes routed
  output logic custom_on // Custom channels routed
);
  logic alt;
  logic usb_set2;
  logic in_usb;

  always_comb begin
    alt = sel.alt_enable_sel && (!sel.alt_family_sel || custom_ok);
    dp_on = alt && !sel.alt_family_sel;
    custom_on = alt && sel.alt_family_sel;
    // Sink side swaps which set carries USB, enables keep their meaning
    usb_set2 = sel.orientation_sel ^ sel.side_sel;
    ch_en = '0;
    ch_u2d = '0;
    in_usb = 1'b0;
    for (int s = 0; s < 2; s++) begin
      in_usb = sel.usb_enable_sel && (usb_set2 == s[0]);
      ch_en[lrcd_pkg::CH_RX1 + s] = in_usb || alt;
      ch_en[lrcd_pkg::CH_TX1 + s] = in_usb || alt;
      // Receive pairs run up to down only for DisplayPort lanes
      ch_u2d[lrcd_pkg::CH_RX1 + s] = dp_on && !in_usb;
      ch_u2d[lrcd_pkg::CH_TX1 + s] = in_usb || alt;
    end
    unique case ({sel.usb_enable_sel, alt})
      2'b00: route = lrcd_pkg::RM_OFF;
      2'b10: route = lrcd_pkg::RM_USB;
      2'b01: route = lrcd_pkg::RM_ALT4;
      2'b11: route = lrcd_pkg::RM_USB_ALT2;
    endcase
  end
endmodule : lrcd_route
`default_nettype wire

// ---- src/lrcd_top.sv ----
// Lane route configuration decoder: selects, registers and crosspoint control
`timescale 1ns/100ps
`default_nettype none
module lrcd_top #(
  parameter int DEBOUNCE_CYCLES = lrcd_pkg::DEBOUNCE_CYCLES
) (
  input wire logic clk, // Core clock, 250 MHz
  input wire logic reset_n, // Synchronous reset
  input wire logic reg_mode_pin, // High: configuration from registers
  input wire logic alt_family_pin, // Custom instead of DisplayPort
  input wire logic side_pin, // Sink side when high
  input wire logic alt_enable_pin, // Alternate mode enable
  input wire logic usb_enable_pin, // USB enable
  input wire logic orientation_pin, // Plug flipped when high
  input wire logic reverse_pin, // Exchange channel input and output
  input wire logic [3:0] dfp_eq_pins, // Downstream gain code
  input wire logic [3:0] ufp_eq_pins, // Upstream gain code
  input wire logic reg_wr_en, // Register write strobe
  input wire logic reg_rd_en, // Register read strobe
  input wire logic [7:0] reg_addr, // Register offset
  input wire logic [7:0] reg_wdata, // Write data
  output logic [7:0] reg_rdata, // Read data, one cycle after strobe
  output logic [3:0] ch_enable, // Channel routed
  output logic [3:0] ch_up_to_down, // Channel drives downstream pins
  output logic [15:0] ch_gain, // Gain step, four bits per channel
  output lrcd_pkg::lrcd_sbu_t sbu, // Aux to sideband switches
  output lrcd_pkg::lrcd_route_t route_mode, // Current route
  output logic dp_enable, // DisplayPort lanes routed
  output logic custom_enable, // Custom channels routed
  output logic usb_track_enable // USB power-state tracking allowed
);
  generate
    if (DEBOUNCE_CYCLES < 1) begin : g_bad
      $error("lrcd_top: DEBOUNCE_CYCLES must be at least 1");
    end
  endgenerate

  typedef struct packed {
    logic [7:0] config_r;
    logic [3:0] ch_reverse;
    logic [7:0] ufp_rx_gain;
    logic [7:0] ufp_tx_gain;
    logic [7:0] dfp_rx_gain;
    logic [7:0] dfp_tx_gain;
    logic [7:0] aux_monitor;
    logic [7:0] rdata;
    logic [3:0] ch_enable;
    logic [3:0] ch_up_to_down;
    logic [15:0] ch_gain;
    lrcd_pkg::lrcd_sbu_t sbu;
    lrcd_pkg::lrcd_route_t route;
    logic dp_en;
    logic custom_en;
    logic usb_track;
  } lrcd_top_state_t;

  lrcd_top_state_t s, next_s;
  lrcd_pkg::lrcd_sel_t pin_sel, reg_sel, sel;
  lrcd_pkg::lrcd_route_t route;
  logic [2:0] db_ctl;
  logic [3:0] base_en, base_u2d, rev_eff;
  logic [1:0] sb_ovr;
  logic custom_ok, dp_on, custom_on;

  // Pick a channel's gain field: low nibble is set 1, high nibble set 2
  function automatic logic [3:0] nib(input logic [7:0] r, input logic hi);
    nib = hi ? r[7:4] : r[3:0];
  endfunction : nib

  lrcd_debounce #(
    .WIDTH(3),
    .CYCLES(DEBOUNCE_CYCLES)
  ) u_debounce (
    .clk(clk),
    .reset_n(reset_n),
    .raw({alt_enable_pin, usb_enable_pin, orientation_pin}),
    .stable(db_ctl)
  );

  always_comb begin
    pin_sel.alt_family_sel = alt_family_pin;
    pin_sel.side_sel = side_pin;
    pin_sel.alt_enable_sel = db_ctl[2];
    pin_sel.usb_enable_sel = db_ctl[1];
    pin_sel.orientation_sel = db_ctl[0];
    reg_sel.alt_family_sel = s.config_r[lrcd_pkg::CFG_FAMILY_BIT];
    reg_sel.side_sel = s.config_r[lrcd_pkg::CFG_SIDE_BIT];
    reg_sel.alt_enable_sel = s.config_r[lrcd_pkg::CFG_ALT_BIT];
    reg_sel.usb_enable_sel = s.config_r[lrcd_pkg::CFG_USB_BIT];
    reg_sel.orientation_sel = s.config_r[lrcd_pkg::CFG_ORIENT_BIT];
    sel = reg_mode_pin ? reg_sel : pin_sel;
    // Monitor disable blocks custom mode only when registers rule
    custom_ok = !reg_mode_pin
      || !s.aux_monitor[lrcd_pkg::MON_DISABLE_BIT];
    sb_ovr = reg_mode_pin
      ? s.config_r[lrcd_pkg::CFG_SB_OVR_LSB +: 2] : lrcd_pkg::SB_AUTO;
  end

  lrcd_route u_route (
    .sel(sel),
    .custom_ok(custom_ok),
    .route(route),
    .ch_en(base_en),
    .ch_u2d(base_u2d),
    .dp_on(dp_on),
    .custom_on(custom_on)
  );

  always_comb begin
    next_s = s;
    // Reverse field of all zeros or all ones keeps the pin behaviour
    if (reg_mode_pin && s.ch_reverse != lrcd_pkg::REV_NONE
        && s.ch_reverse != lrcd_pkg::REV_ALL) begin
      rev_eff = s.ch_reverse;
    end else begin
      rev_eff = {4{reverse_pin}};
    end
    next_s.route = route;
    next_s.ch_enable = base_en;
    next_s.ch_up_to_down = (base_u2d ^ rev_eff) & base_en;
    for (int c = 0; c < lrcd_pkg::NUM_CH; c++) begin
      // Gain source follows the unreversed entry side
      if (!reg_mode_pin) begin
        next_s.ch_gain[4*c +: 4] = base_u2d[c] ? ufp_eq_pins
          : dfp_eq_pins;
      end else if (c < lrcd_pkg::CH_TX1) begin
        next_s.ch_gain[4*c +: 4] = base_u2d[c]
          ? nib(s.ufp_rx_gain, c[0]) : nib(s.dfp_rx_gain, c[0]);
      end else begin
        next_s.ch_gain[4*c +: 4] = base_u2d[c]
          ? nib(s.ufp_tx_gain, c[0]) : nib(s.dfp_tx_gain, c[0]);
      end
    end
    unique case (sb_ovr)
      lrcd_pkg::SB_AUTO: begin
        next_s.sbu.p_to_sb1 = sel.alt_enable_sel && !sel.orientation_sel;
        next_s.sbu.n_to_sb2 = sel.alt_enable_sel && !sel.orientation_sel;
        next_s.sbu.p_to_sb2 = sel.alt_enable_sel && sel.orientation_sel;
        next_s.sbu.n_to_sb1 = sel.alt_enable_sel && sel.orientation_sel;
      end
      lrcd_pkg::SB_STRAIGHT: next_s.sbu = 4'hC;
      lrcd_pkg::SB_CROSSED: next_s.sbu = 4'h3;
      lrcd_pkg::SB_OPEN: next_s.sbu = 4'h0;
    endcase
    next_s.dp_en = dp_on;
    next_s.custom_en = custom_on;
    next_s.usb_track = sel.usb_enable_sel;
    if (reg_wr_en) begin
      unique case (reg_addr)
        lrcd_pkg::OFS_CONFIG: next_s.config_r = reg_wdata;
        lrcd_pkg::OFS_CH_REVERSE: next_s.ch_reverse = reg_wdata[3:0];
        lrcd_pkg::OFS_UFP_RX_GAIN: next_s.ufp_rx_gain = reg_wdata;
        lrcd_pkg::OFS_UFP_TX_GAIN: next_s.ufp_tx_gain = reg_wdata;
        lrcd_pkg::OFS_DFP_RX_GAIN: next_s.dfp_rx_gain = reg_wdata;
        lrcd_pkg::OFS_DFP_TX_GAIN: next_s.dfp_tx_gain = reg_wdata;
        lrcd_pkg::OFS_AUX_MONITOR: next_s.aux_monitor = reg_wdata;
        default: ;
      endcase
    end
    if (reg_rd_en) begin
      unique case (reg_addr)
        lrcd_pkg::OFS_CONFIG: next_s.rdata = s.config_r;
        lrcd_pkg::OFS_CH_REVERSE: next_s.rdata = {4'h0, s.ch_reverse};
        lrcd_pkg::OFS_UFP_RX_GAIN: next_s.rdata = s.ufp_rx_gain;
        lrcd_pkg::OFS_UFP_TX_GAIN: next_s.rdata = s.ufp_tx_gain;
        lrcd_pkg::OFS_DFP_RX_GAIN: next_s.rdata = s.dfp_rx_gain;
        lrcd_pkg::OFS_DFP_TX_GAIN: next_s.rdata = s.dfp_tx_gain;
        lrcd_pkg::OFS_AUX_MONITOR: next_s.rdata = s.aux_monitor;
        lrcd_pkg::OFS_STATUS: next_s.rdata = {1'b0, reg_mode_pin,
          s.route, s.ch_enable};
        default: next_s.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s <= '0;
      s.config_r <= lrcd_pkg::RST_CONFIG;
      s.ch_reverse <= lrcd_pkg::RST_CH_REVERSE;
      s.ufp_rx_gain <= lrcd_pkg::RST_GAIN;
      s.ufp_tx_gain <= lrcd_pkg::RST_GAIN;
      s.dfp_rx_gain <= lrcd_pkg::RST_GAIN;
      s.dfp_tx_gain <= lrcd_pkg::RST_GAIN;
      s.aux_monitor <= lrcd_pkg::RST_AUX_MONITOR;
      s.route <= lrcd_pkg::RM_OFF;
    end else begin
      s <= next_s;
    end
  end

  assign reg_rdata = s.rdata;
  assign ch_enable = s.ch_enable;
  assign ch_up_to_down = s.ch_up_to_down;
  assign ch_gain = s.ch_gain;
  assign sbu = s.sbu;
  assign route_mode = s.route;
  assign dp_enable = s.dp_en;
  assign custom_enable = s.custom_en;
  assign usb_track_enable = s.usb_track;

  a_reg_sel_source: assert property (
    @(posedge clk) disable iff (!reset_n)
    $past(reset_n) && $past(reg_mode_pin) && $past(reg_sel == 5'h02)
    |-> ch_enable == 4'h5 && route_mode == lrcd_pkg::RM_USB)
    else $error("register selects not obeyed in register mode");

  a_usb_only_pair: assert property (
    @(posedge clk) disable iff (!reset_n)
    $past(reset_n) && $past(sel.usb_enable_sel && !sel.alt_enable_sel)
    |-> $countones(ch_enable) == 2 && !dp_enable)
    else $error("USB-only route does not use exactly one lane pair");

  a_dp_four_lane: assert property (
    @(posedge clk) disable iff (!reset_n)
    $past(reset_n) && $past(sel.alt_enable_sel && !sel.usb_enable_sel
      && !sel.alt_family_sel)
    |-> ch_enable == 4'hF && ch_up_to_down == ~$past(rev_eff) && dp_enable)
    else $error("four-lane DisplayPort route wrong");

  a_usb_alt_mix: assert property (
    @(posedge clk) disable iff (!reset_n)
    $past(reset_n) && $past(sel.alt_enable_sel && sel.usb_enable_sel
      && custom_ok)
    |-> ch_enable == 4'hF && route_mode == lrcd_pkg::RM_USB_ALT2)
    else $error("USB plus two-lane route wrong");

  a_custom_source_dir: assert property (
    @(posedge clk) disable iff (!reset_n)
    $past(reset_n) && $past(sel.alt_enable_sel && sel.alt_family_sel
      && custom_ok && !sel.side_sel)
    |-> (ch_up_to_down ^ $past(rev_eff)) == 4'hC && custom_enable)
    else $error("custom source directions wrong");

  a_sink_usb_set: assert property (
    @(posedge clk) disable iff (!reset_n)
    $past(reset_n) && $past(sel.usb_enable_sel && !sel.alt_enable_sel
      && sel.side_sel)
    |-> ch_enable == ($past(sel.orientation_sel) ? 4'h5 : 4'hA))
    else $error("sink USB lane set does not follow orientation");

  a_reverse_pin_dir: assert property (
    @(posedge clk) disable iff (!reset_n)
    $past(reset_n) && $past(!reg_mode_pin && reverse_pin)
      && $past(pin_sel == 5'h02)
    |-> ch_up_to_down == 4'h1 && ch_gain[3:0] == $past(dfp_eq_pins))
    else $error("reversed channel direction or gain source wrong");

  a_sideband_map: assert property (
    @(posedge clk) disable iff (!reset_n)
    $past(reset_n) && $past(sb_ovr == lrcd_pkg::SB_AUTO)
      && $past(sel.alt_enable_sel && !sel.orientation_sel)
    |-> sbu.p_to_sb1 && sbu.n_to_sb2 && !sbu.p_to_sb2 && !sbu.n_to_sb1)
    else $error("aux to sideband straight mapping wrong");

  a_sideband_cross: assert property (
    @(posedge clk) disable iff (!reset_n)
    $past(reset_n) && ($past(sb_ovr == lrcd_pkg::SB_CROSSED)
      || $past(sb_ovr == lrcd_pkg::SB_AUTO && sel.alt_enable_sel
      && sel.orientation_sel))
    |-> sbu == 4'h3)
    else $error("aux to sideband crossed mapping wrong");

  a_sideband_open: assert property (
    @(posedge clk) disable iff (!reset_n)
    $past(reset_n) && ($past(sb_ovr == lrcd_pkg::SB_OPEN)
      || $past(sb_ovr == lrcd_pkg::SB_AUTO && !sel.alt_enable_sel))
    |-> sbu == 4'h0)
    else $error("sideband switches not open");

  a_power_down: assert property (
    @(posedge clk) disable iff (!reset_n)
    $past(reset_n) && $past(!sel.usb_enable_sel && !sel.alt_enable_sel)
    |-> ch_enable == 4'h0 && route_mode == lrcd_pkg::RM_OFF)
    else $error("channels not powered down");

  a_monitor_gate: assert property (
    @(posedge clk) disable iff (!reset_n)
    $past(reset_n) && $past(reg_mode_pin && !sel.usb_enable_sel)
      && $past(s.aux_monitor[lrcd_pkg::MON_DISABLE_BIT] && sel.alt_family_sel)
    |-> ch_enable == 4'h0 && !custom_enable)
    else $error("custom mode ran with monitor disable set");

  a_dp_gain_src: assert property (
    @(posedge clk) disable iff (!reset_n)
    $past(reset_n) && $past(!reg_mode_pin && dp_on && !sel.usb_enable_sel)
    |-> ch_gain == {4{$past(ufp_eq_pins)}})
    else $error("DisplayPort lanes not on upstream gain");

  a_usb_tracking: assert property (
    @(posedge clk) disable iff (!reset_n)
    $past(reset_n) |-> usb_track_enable == $past(sel.usb_enable_sel))
    else $error("USB tracking enable does not follow USB enable");
endmodule : lrcd_top
`default_nettype wire

// ---- testbench/lrcd_ctrl_model.sv ----
// Controller model: drives configuration pins and the register port
`timescale 1ns/100ps
`default_nettype none
module lrcd_ctrl_model (
  input wire logic clk, // Core clock
  input wire logic [7:0] reg_rdata, // Read data
  output logic reg_mode_pin, // Register mode select
  output lrcd_pkg::lrcd_sel_t pins, // Selects as pin levels
  output logic reverse_pin, // Channel reverse
  output logic [3:0] dfp_eq_pins, // Downstream gain code
  output logic [3:0] ufp_eq_pins, // Upstream gain code
  output logic reg_wr_en, // Write strobe
  output logic reg_rd_en, // Read strobe
  output logic [7:0] reg_addr, // Register offset
  output logic [7:0] reg_wdata // Write data
);
  initial begin
    {reg_mode_pin, pins, reverse_pin} = '0;
    {dfp_eq_pins, ufp_eq_pins} = '0;
    {reg_wr_en, reg_rd_en, reg_addr, reg_wdata} = '0;
  end

  // Changes land on the falling edge, clear of the sampling edge
  task automatic set_pins(input logic mode, input lrcd_pkg::lrcd_sel_t s,
      input logic rev, input logic [3:0] deq, input logic [3:0] ueq);
    @(negedge clk);
    reg_mode_pin = mode;
    pins = s;
    reverse_pin = rev;
    dfp_eq_pins = deq;
    ufp_eq_pins = ueq;
  endtask : set_pins

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr_en = 1'b1;
    @(negedge clk);
    reg_wr_en = 1'b0;
  endtask : wr

  // Read data is registered, so it is taken a cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_rd_en = 1'b1;
    @(negedge clk);
    reg_rd_en = 1'b0;
    d = reg_rdata;
  endtask : rd

  // Custom channels stay blocked in register mode while the monitor disable bit is set
  task automatic custom_allow(input logic allow);
    wr(lrcd_pkg::OFS_AUX_MONITOR, allow ? 8'h00 : 8'h80);
  endtask : custom_allow
endmodule : lrcd_ctrl_model
`default_nettype wire

// ---- testbench/test_lane_route_config_decode.sv ----
// Testbench for the lane route configuration decoder
`timescale 1ns/100ps
`default_nettype none
module test_lane_route_config_decode;
  logic clk;
  logic reset_n;
  logic reg_mode_pin;
  lrcd_pkg::lrcd_sel_t pins;
  logic reverse_pin;
  logic [3:0] dfp_eq_pins;
  logic [3:0] ufp_eq_pins;
  logic reg_wr_en;
  logic reg_rd_en;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic [3:0] ch_enable;
  logic [3:0] ch_up_to_down;
  logic [15:0] ch_gain;
  lrcd_pkg::lrcd_sbu_t sbu;
  lrcd_pkg::lrcd_route_t route_mode;
  logic dp_enable;
  logic custom_enable;
  logic usb_track_enable;
  int n_fail;
  int n_tests;
  logic [7:0] offs [9] = '{8'h0A, 8'h0B, 8'h10, 8'h11, 8'h13, 8'h14,
    8'h20, 8'h21, 8'h55};
  logic [7:0] rsts [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h80, 8'h00,
    8'h00, 8'h00, 8'h00};
  // Reverse cases: expected mask, reverse pin, field
  logic [11:0] rv [6] = '{12'h505, 12'hA1A, 12'hF1F, 12'h00F, 12'hF10,
    12'h000};

  lrcd_top #(.DEBOUNCE_CYCLES(8)) dut (.clk(clk), .reset_n(reset_n),
    .reg_mode_pin(reg_mode_pin), .alt_family_pin(pins.alt_family_sel),
    .side_pin(pins.side_sel), .alt_enable_pin(pins.alt_enable_sel),
    .usb_enable_pin(pins.usb_enable_sel),
    .orientation_pin(pins.orientation_sel), .reverse_pin(reverse_pin),
    .dfp_eq_pins(dfp_eq_pins), .ufp_eq_pins(ufp_eq_pins),
    .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .ch_enable(ch_enable),
    .ch_up_to_down(ch_up_to_down), .ch_gain(ch_gain), .sbu(sbu),
    .route_mode(route_mode), .dp_enable(dp_enable),
    .custom_enable(custom_enable), .usb_track_enable(usb_track_enable));

  lrcd_ctrl_model ctrl (.clk(clk), .reg_rdata(reg_rdata),
    .reg_mode_pin(reg_mode_pin), .pins(pins), .reverse_pin(reverse_pin),
    .dfp_eq_pins(dfp_eq_pins), .ufp_eq_pins(ufp_eq_pins),
    .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata));

  task automatic finish_test;
    $display("Checks made: %0d, mismatches: %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : finish_test

  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
      input string what);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask : idle

  // Returns {enable, upstream-to-downstream} before any reversal
  function automatic logic [7:0] exp_route(input lrcd_pkg::lrcd_sel_t s);
    logic set2;
    set2 = s.orientation_sel ^ s.side_sel;
    if (!s.alt_enable_sel && !s.usb_enable_sel)
      return 8'h00;
    if (!s.alt_enable_sel)
      return set2 ? 8'hA8 : 8'h54;
    if (s.alt_family_sel)
      return 8'hFC;
    if (!s.usb_enable_sel)
      return 8'hFF;
    return set2 ? 8'hFD : 8'hFE;
  endfunction : exp_route

  function automatic logic [3:0] exp_sbu(input logic [1:0] ovr,
      input lrcd_pkg::lrcd_sel_t s);
    if (ovr == 2'h0)
      return s.alt_enable_sel ? (s.orientation_sel ? 4'h3 : 4'hC) : 4'h0;
    return (ovr == 2'h1) ? 4'hC : (ovr == 2'h2) ? 4'h3 : 4'h0;
  endfunction : exp_sbu

  task automatic check_route(input lrcd_pkg::lrcd_sel_t s,
      input logic [1:0] ovr, input logic [3:0] rev,
      input logic [15:0] ug, input logic [15:0] dg);
    logic [7:0] e;
    logic [3:0] g;
    logic alt;
    e = exp_route(s);
    alt = s.alt_enable_sel;
    chk(ch_enable, e[7:4], "enable");
    chk(ch_up_to_down, (e[3:0] ^ rev) & e[7:4], "dir");
    for (int c = 0; c < 4; c++) begin
      g = e[c] ? ug[4*c+:4] : dg[4*c+:4];
      if (e[4+c])
        chk(ch_gain[4*c+:4], g, "gain");
    end
    chk(sbu, exp_sbu(ovr, s), "sideband");
    chk(route_mode, {alt, s.usb_enable_sel}, "route");
    chk({dp_enable, custom_enable, usb_track_enable}, {alt &
      !s.alt_family_sel, alt & s.alt_family_sel, s.usb_enable_sel},
      "flags");
  endtask : check_route

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    $display("FAIL at %0t: run did not complete", $time);
    finish_test();
  end

  initial begin
    logic [7:0] d;
    logic [7:0] cfg;
    lrcd_pkg::lrcd_sel_t s;
    n_fail = 0;
    n_tests = 0;
    reset_n = 1'b0;
    repeat (16) @(negedge clk);
    reset_n = 1'b1;
    chk(ch_enable, 4'h0, "reset enable");
    ctrl.wr(8'h55, 8'hFF);
    ctrl.wr(lrcd_pkg::OFS_STATUS, 8'hFF);
    foreach (offs[k]) begin
      ctrl.rd(offs[k], d);
      chk(d, rsts[k], "register reset");
    end
    $display("Test register reset done");
    for (int i = 0; i < 64; i++) begin
      s = i[4:0];
      ctrl.set_pins(1'b0, s, i[5], i[3:0], ~i[3:0]);
      idle(12);
      check_route(s, 2'h0, {4{i[5]}}, {4{~i[3:0]}}, {4{i[3:0]}});
    end
    $display("Test pin decode done");
    ctrl.set_pins(1'b0, 5'h00, 1'b0, 4'h0, 4'h0);
    idle(12);
    ctrl.set_pins(1'b0, 5'h02, 1'b0, 4'h0, 4'h0);
    idle(3);
    ctrl.set_pins(1'b0, 5'h00, 1'b0, 4'h0, 4'h0);
    idle(12);
    chk(ch_enable, 4'h0, "glitch");
    ctrl.set_pins(1'b0, 5'h02, 1'b0, 4'h0, 4'h0);
    idle(4);
    chk(ch_enable, 4'h0, "early");
    idle(7);
    chk(ch_enable, 4'h5, "debounced");
    $display("Test debounce done");
    ctrl.set_pins(1'b1, 5'h06, 1'b0, 4'h9, 4'h9);
    ctrl.wr(8'h10, 8'h21);
    ctrl.wr(8'h11, 8'h43);
    ctrl.wr(8'h20, 8'h65);
    ctrl.wr(8'h21, 8'h87);
    ctrl.custom_allow(1'b1);
    for (int j = 0; j < 128; j++) begin
      s = j[4:0];
      cfg = {1'b0, j[6:5], s.alt_family_sel, s.side_sel, s.orientation_sel,
        s.alt_enable_sel, s.usb_enable_sel};
      ctrl.wr(lrcd_pkg::OFS_CONFIG, cfg);
      ctrl.rd(lrcd_pkg::OFS_CONFIG, d);
      chk(d, cfg, "config readback");
      check_route(s, j[6:5], 4'h0, 16'h4321, 16'h8765);
    end
    $display("Test register decode done");
    ctrl.wr(lrcd_pkg::OFS_CONFIG, 8'h02);
    foreach (rv[k]) begin
      ctrl.set_pins(1'b1, 5'h06, rv[k][4], 4'h9, 4'h9);
      ctrl.wr(lrcd_pkg::OFS_CH_REVERSE, {4'h0, rv[k][3:0]});
      idle(2);
      check_route(5'h04, 2'h0, rv[k][11:8], 16'h4321, 16'h8765);
    end
    ctrl.rd(lrcd_pkg::OFS_STATUS, d);
    chk(d, 8'h6F, "status");
    $display("Test channel reverse done");
    ctrl.custom_allow(1'b0);
    // Custom alone while blocked must leave every channel down
    ctrl.wr(lrcd_pkg::OFS_CONFIG, 8'h72);
    idle(2);
    check_route(5'h10, 2'h3, 4'h0, 16'h4321, 16'h8765);
    ctrl.wr(lrcd_pkg::OFS_CONFIG, 8'h73);
    idle(2);
    check_route(5'h12, 2'h3, 4'h0, 16'h4321, 16'h8765);
    ctrl.custom_allow(1'b1);
    idle(2);
    check_route(5'h16, 2'h3, 4'h0, 16'h4321, 16'h8765);
    $display("Test custom gating done");
    finish_test();
  end
endmodule : test_lane_route_config_decode
`default_nettype wire
